// ===== hdl/pmr_result_regs.sv
// power monitor result register bank with alert configuration
`timescale 1ns/100ps
module pmr_result_regs (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_o,
   output logic             o_sda_oe,
   output logic             o_alert_o,
   output logic             o_alert_oe,
   input  wire logic        i_result_valid,
   input  wire logic [19:0] i_shunt_v,
   input  wire logic [19:0] i_bus_v,
   input  wire logic [15:0] i_die_temp,
   input  wire logic [19:0] i_current,
   input  wire logic [23:0] i_power,
   input  wire logic [39:0] i_energy,
   input  wire logic [39:0] i_charge,
   input  wire logic        i_conv_done,
   input  wire logic        i_fault_sample,
   input  wire logic        i_fault_avg,
   output logic [14:0]      o_shunt_scale_constant,
   output logic [13:0]      o_shunt_drift_coefficient,
   output logic [16:0]      o_drift_temp_delta,
   output logic             o_averaged_compare_select,
   output logic             o_alert_flag
);
   logic [14:0] scale_r;
   logic [13:0] drift_r;
   logic        latch_r;
   logic        conversion_done_alert_enable_r;
   logic        slow_r;
   logic        alert_flag_r;
   logic        alert_flag_nxt;
   logic        cnvrf_r;
   logic        alert_pin_r;
   logic [19:0] shunt_v_r;
   logic [19:0] bus_v_r;
   logic [15:0] die_temp_r;
   logic [19:0] current_r;
   logic [23:0] power_r;
   logic [39:0] energy_r;
   logic [39:0] charge_r;
   logic [16:0] delta_r;
   logic [7:0]  ptr_r;
   logic [7:0]  hi_byte_r;
   logic        wr_phase_r;
   logic [39:0] tx_buf_r;
   logic        rd_start;
   logic        rd_next;
   logic        rx_valid;
   logic        rx_ptr;
   logic [7:0]  rx_byte;
   logic        wr_commit;
   logic [15:0] wr_word;
   logic        diag_rd;
   logic        fault_src;

   // readback value, left aligned so the first byte sent is always bits 39-32
   function automatic logic [39:0] pmr_read_word(input logic [7:0] ptr);
      logic [39:0] v;
      v = 40'h00_0000_0000;
      unique case (ptr)
         pmr_pkg::OFS_SCALE:   v = {1'b0, scale_r, 24'h00_0000};
         pmr_pkg::OFS_DRIFT:   v = {2'h0, drift_r, 24'h00_0000};
         pmr_pkg::OFS_SHUNT:   v = {shunt_v_r, 4'h0, 16'h0000};
         pmr_pkg::OFS_BUS:     v = {bus_v_r, 4'h0, 16'h0000};
         pmr_pkg::OFS_TEMP:    v = {die_temp_r, 24'h00_0000};
         pmr_pkg::OFS_CURRENT: v = {current_r, 4'h0, 16'h0000};
         pmr_pkg::OFS_POWER:   v = {power_r, 16'h0000};
         pmr_pkg::OFS_ENERGY:  v = energy_r;
         pmr_pkg::OFS_CHARGE:  v = charge_r;
         pmr_pkg::OFS_DIAG: begin
            v[39:24]                  = 16'h0000;
            v[24 + pmr_pkg::BIT_LATCH]  = latch_r;
            v[24 + pmr_pkg::BIT_CONVERSION_DONE_ALERT_ENABLE]   = conversion_done_alert_enable_r;
            v[24 + pmr_pkg::BIT_SLOW]   = slow_r;
            v[24 + pmr_pkg::BIT_ALERTF] = alert_flag_r;
            v[24 + pmr_pkg::BIT_CNVRF]  = cnvrf_r;
            v[24]                     = pmr_pkg::DIAG_RST[0];
         end
         default:              v = 40'h00_0000_0000;
      endcase
      return v;
   endfunction : pmr_read_word

   pmr_i2c_slave u_serial (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_sda_oe   (o_sda_oe),
      .o_rd_start (rd_start),
      .o_rd_next  (rd_next),
      .i_tx_byte  (tx_buf_r[39:32]),
      .o_rx_valid (rx_valid),
      .o_rx_ptr   (rx_ptr),
      .o_rx_byte  (rx_byte)
   );

   // open drain: only ever pulls low
   assign o_sda_o   = 1'b0;
   assign o_alert_o = 1'b0;

   // write decode; a word commits on its low byte
   assign wr_commit = rx_valid & ~rx_ptr & wr_phase_r;
   assign wr_word   = {hi_byte_r, rx_byte};
   assign diag_rd   = rd_start & (ptr_r == pmr_pkg::OFS_DIAG);

   // pointer and byte pairing
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ptr_r      <= 8'h00;
         hi_byte_r  <= 8'h00;
         wr_phase_r <= 1'b0;
      end else if (rx_valid && rx_ptr) begin
         ptr_r      <= rx_byte;
         wr_phase_r <= 1'b0;
      end else if (rx_valid) begin
         hi_byte_r  <= rx_byte;
         wr_phase_r <= ~wr_phase_r;
      end
   end

   // writable fields; reserved upper bits are dropped on the way in
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scale_r <= pmr_pkg::SCALE_RST;
         drift_r <= pmr_pkg::DRIFT_RST;
         latch_r <= pmr_pkg::DIAG_RST[pmr_pkg::BIT_LATCH];
         conversion_done_alert_enable_r  <= pmr_pkg::DIAG_RST[pmr_pkg::BIT_CONVERSION_DONE_ALERT_ENABLE];
         slow_r  <= pmr_pkg::DIAG_RST[pmr_pkg::BIT_SLOW];
      end else if (wr_commit) begin
         if (ptr_r == pmr_pkg::OFS_SCALE) begin
            scale_r <= wr_word[14:0];
         end
         if (ptr_r == pmr_pkg::OFS_DRIFT) begin
            drift_r <= wr_word[13:0];
         end
         if (ptr_r == pmr_pkg::OFS_DIAG) begin
            latch_r <= wr_word[pmr_pkg::BIT_LATCH];
            conversion_done_alert_enable_r  <= wr_word[pmr_pkg::BIT_CONVERSION_DONE_ALERT_ENABLE];
            slow_r  <= wr_word[pmr_pkg::BIT_SLOW];
         end
      end
   end

   // all results load together so no register mixes two conversions
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shunt_v_r  <= 20'h0_0000;
         bus_v_r    <= 20'h0_0000;
         die_temp_r <= 16'h0000;
         current_r  <= 20'h0_0000;
         power_r    <= 24'h00_0000;
         energy_r   <= 40'h00_0000_0000;
         charge_r   <= 40'h00_0000_0000;
      end else if (i_result_valid) begin
         shunt_v_r  <= i_shunt_v;
         bus_v_r    <= i_bus_v;
         die_temp_r <= i_die_temp;
         current_r  <= i_current;
         power_r    <= i_power;
         energy_r   <= i_energy;
         charge_r   <= i_charge;
      end
   end

   // temperature offset from +25 C for the shunt drift correction
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         delta_r <= 17'h0_0000;
      end else begin
         delta_r <= 17'({die_temp_r[15], die_temp_r} - {1'b0, pmr_pkg::REF_TEMP});
      end
   end

   // snapshot taken once per read; later updates cannot tear the bytes
   // bytes past the last defined one shift in as zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_buf_r <= 40'h00_0000_0000;
      end else if (rd_start) begin
         tx_buf_r <= pmr_read_word(ptr_r);
      end else if (rd_next) begin
         tx_buf_r <= {tx_buf_r[31:0], 8'h00};
      end
   end

   // comparison source and alert flag; a new fault wins over a read clear
   always_comb begin
      fault_src = slow_r ? i_fault_avg : i_fault_sample;
      if (latch_r) begin
         alert_flag_nxt = fault_src | (alert_flag_r & ~diag_rd);
      end else begin
         alert_flag_nxt = fault_src;
      end
   end

   // flags and pin drive
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         alert_flag_r <= 1'b0;
         cnvrf_r      <= 1'b0;
         alert_pin_r  <= 1'b0;
      end else begin
         alert_flag_r <= alert_flag_nxt;
         cnvrf_r      <= i_conv_done | (cnvrf_r & ~diag_rd);
         alert_pin_r  <= alert_flag_r | (conversion_done_alert_enable_r & cnvrf_r);
      end
   end

   assign o_shunt_scale_constant    = scale_r;
   assign o_shunt_drift_coefficient = drift_r;
   assign o_drift_temp_delta        = delta_r;
   assign o_averaged_compare_select = slow_r;
   assign o_alert_flag              = alert_flag_r;
   assign o_alert_oe                = alert_pin_r;

   // checks on the bank behaviour
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_scale_hold;
      !(wr_commit && ptr_r == pmr_pkg::OFS_SCALE) |=> $stable(o_shunt_scale_constant);
   endproperty
   a_scale_hold: assert property (p_scale_hold) else $error("scale changed without write");

   property p_reserved_zero;
      rd_start && (ptr_r == pmr_pkg::OFS_SCALE) |=> tx_buf_r[39] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit not zero");

   property p_drift_write;
      wr_commit && ptr_r == pmr_pkg::OFS_DRIFT
         |=> o_shunt_drift_coefficient == $past(wr_word[13:0]);
   endproperty
   a_drift_write: assert property (p_drift_write) else $error("drift write lost");

   property p_ref_temp;
      i_result_valid |-> ##2
         (17'(o_drift_temp_delta + {1'b0, pmr_pkg::REF_TEMP})
            == {$past(i_die_temp[15], 2), $past(i_die_temp, 2)});
   endproperty
   a_ref_temp: assert property (p_ref_temp) else $error("drift delta not from 25 C");

   // the reserved nibble below the field must stay zero
   property p_shunt_field;
      rd_start && ptr_r == pmr_pkg::OFS_SHUNT
         |=> tx_buf_r[39:16] == {$past(shunt_v_r), 4'h0};
   endproperty
   a_shunt_field: assert property (p_shunt_field) else $error("shunt field misplaced");

   property p_power_field;
      rd_start && ptr_r == pmr_pkg::OFS_POWER |=> tx_buf_r[39:16] == $past(power_r);
   endproperty
   a_power_field: assert property (p_power_field) else $error("power field misplaced");

   property p_energy_field;
      rd_start && ptr_r == pmr_pkg::OFS_ENERGY |=> tx_buf_r == $past(energy_r);
   endproperty
   a_energy_field: assert property (p_energy_field) else $error("energy field wrong");

   property p_transparent;
      !latch_r && !fault_src |=> !alert_flag_r ##1 !(o_alert_oe && !$past(conversion_done_alert_enable_r && cnvrf_r));
   endproperty
   a_transparent: assert property (p_transparent) else $error("alert stuck in transparent");

   sequence s_latched_fault;
      latch_r && fault_src;
   endsequence
   sequence s_no_clear;
      (latch_r && !diag_rd)[*3];
   endsequence
   property p_latch_hold;
      s_latched_fault ##1 s_no_clear |=> alert_flag_r && o_alert_oe;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched alert dropped");

   property p_conversion_done_alert_enable_route;
      conversion_done_alert_enable_r && cnvrf_r |=> o_alert_oe;
   endproperty
   a_conversion_done_alert_enable_route: assert property (p_conversion_done_alert_enable_route) else $error("ready not routed to alert");

   property p_avg_select;
      !latch_r && slow_r && i_fault_avg == !i_fault_sample |=> alert_flag_r == $past(i_fault_avg);
   endproperty
   a_avg_select: assert property (p_avg_select) else $error("wrong comparison source");

   // the buffer loads on the edge after the start, so stability is judged a cycle later
   property p_snapshot;
      rd_start ##1 (!rd_start && !rd_next) |=> $stable(tx_buf_r);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("read buffer torn");
endmodule : pmr_result_regs

// ===== shared/pmr_pkg.sv
// register map, field positions and reset values of the power monitor result bank
// What this block does
// - 15-bit scale constant, resets 1000h, feeds current
// - reserved register bits read zero, except diagnostic bit 0, which reads 1
// - 14-bit drift coefficient, 1 ppm/C, resets zero
// - drift correction referenced to +25 C
// - shunt voltage: 20-bit signed in bits 23-4
// - bus voltage: 20-bit signed, never negative
// - die temperature: 16-bit signed, 7.8125 mC/LSB
// - current: signed amperes in bits 23-4
// - power: 24-bit unsigned watts, read only
// - energy: 40-bit unsigned joules, read only
// - charge: 40-bit signed coulombs, read only
// - transparent mode: alert idles when fault clears
// - latched mode: alert holds until diagnostic read
// - enable bit routes conversion-ready flag to alert
// - select averaged or raw sample for comparison
package pmr_pkg;
   // serial address, arbitrary default
   localparam logic [6:0]  DEV_ADDR     = 7'h40;
   // register pointers
   localparam logic [7:0]  OFS_SCALE    = 8'h02;
   localparam logic [7:0]  OFS_DRIFT    = 8'h03;
   localparam logic [7:0]  OFS_SHUNT    = 8'h04;
   localparam logic [7:0]  OFS_BUS      = 8'h05;
   localparam logic [7:0]  OFS_TEMP     = 8'h06;
   localparam logic [7:0]  OFS_CURRENT  = 8'h07;
   localparam logic [7:0]  OFS_POWER    = 8'h08;
   localparam logic [7:0]  OFS_ENERGY   = 8'h09;
   localparam logic [7:0]  OFS_CHARGE   = 8'h0A;
   localparam logic [7:0]  OFS_DIAG     = 8'h0B;
   // reset values
   localparam logic [14:0] SCALE_RST    = 15'h1000;
   localparam logic [13:0] DRIFT_RST    = 14'h0000;
   localparam logic [15:0] DIAG_RST     = 16'h0001;
   // diagnostic field positions
   localparam int          BIT_LATCH    = 15;
   localparam int          BIT_CONVERSION_DONE_ALERT_ENABLE     = 14;
   localparam int          BIT_SLOW     = 13;
   localparam int          BIT_ALERTF   = 7;
   localparam int          BIT_CNVRF    = 1;
   // +25 C expressed in die temperature LSBs of 7.8125 mC
   localparam logic [15:0] REF_TEMP     = 16'h0C80;
   // serial engine bit count per byte
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
endpackage : pmr_pkg

// ===== hdl/pmr_i2c_slave.sv
// serial management slave: byte engine feeding the register bank
`timescale 1ns/100ps
module pmr_i2c_slave (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_oe,
   output logic            o_rd_start,
   output logic            o_rd_next,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_rx_valid,
   output logic            o_rx_ptr,
   output logic [7:0]      o_rx_byte
);
   typedef enum logic [6:0] {
      st_idle = 7'b0000001,
      st_addr = 7'b0000010,
      st_aack = 7'b0000100,
      st_rx   = 7'b0001000,
      st_rack = 7'b0010000,
      st_tx   = 7'b0100000,
      st_tack = 7'b1000000
   } pmr_i2c_state_t;

   pmr_i2c_state_t state_r;
   logic [2:0]     scl_sync_r;
   logic [2:0]     sda_sync_r;
   logic [7:0]     sh_r;
   logic [3:0]     cnt_r;
   logic           rw_r;
   logic           first_r;
   logic           scl_rise;
   logic           scl_fall;
   logic           start_cond;
   logic           stop_cond;
   logic           sda_in;

   // two flops before use; stage 3 only serves edge detection
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], i_scl};
         sda_sync_r <= {sda_sync_r[1:0], i_sda};
      end
   end

   // bus conditions from the synchronised levels
   assign sda_in     = sda_sync_r[1];
   assign scl_rise   = scl_sync_r[1] & ~scl_sync_r[2];
   assign scl_fall   = ~scl_sync_r[1] & scl_sync_r[2];
   assign start_cond = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] & ~sda_sync_r[1];
   assign stop_cond  = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] & sda_sync_r[1];

   // byte engine; data only changes after scl falls so setup is met
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r    <= st_idle;
         sh_r       <= 8'h00;
         cnt_r      <= 4'h0;
         rw_r       <= 1'b0;
         first_r    <= 1'b0;
         o_sda_oe   <= 1'b0;
         o_rd_start <= 1'b0;
         o_rd_next  <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_ptr   <= 1'b0;
         o_rx_byte  <= 8'h00;
      end else begin
         o_rd_start <= 1'b0;
         o_rd_next  <= 1'b0;
         o_rx_valid <= 1'b0;
         if (start_cond) begin
            state_r  <= st_addr;
            cnt_r    <= 4'h0;
            first_r  <= 1'b1;
            o_sda_oe <= 1'b0;
         end else if (stop_cond) begin
            state_r  <= st_idle;
            o_sda_oe <= 1'b0;
         end else begin
            unique case (state_r)
               st_idle: begin
               end
               st_addr, st_rx: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda_in};
                     cnt_r <= 4'(cnt_r + 4'h1);
                  end else if (scl_fall && cnt_r == pmr_pkg::BITS_PER_BYTE) begin
                     cnt_r <= 4'h0;
                     if (state_r == st_rx) begin
                        o_sda_oe   <= 1'b1;
                        o_rx_valid <= 1'b1;
                        o_rx_ptr   <= first_r;
                        o_rx_byte  <= sh_r;
                        first_r    <= 1'b0;
                        state_r    <= st_rack;
                     end else if (sh_r[7:1] == pmr_pkg::DEV_ADDR) begin
                        o_sda_oe   <= 1'b1;
                        rw_r       <= sh_r[0];
                        o_rd_start <= sh_r[0];
                        state_r    <= st_aack;
                     end else begin
                        state_r <= st_idle;
                     end
                  end
               end
               st_aack: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (rw_r) begin
                        sh_r     <= i_tx_byte;
                        o_sda_oe <= ~i_tx_byte[7];
                        state_r  <= st_tx;
                     end else begin
                        o_sda_oe <= 1'b0;
                        state_r  <= st_rx;
                     end
                  end
               end
               st_rack: begin
                  if (scl_fall) begin
                     o_sda_oe <= 1'b0;
                     state_r  <= st_rx;
                  end
               end
               st_tx: begin
                  if (scl_rise) begin
                     cnt_r <= 4'(cnt_r + 4'h1);
                  end else if (scl_fall) begin
                     if (cnt_r == pmr_pkg::BITS_PER_BYTE) begin
                        o_sda_oe <= 1'b0;
                        state_r  <= st_tack;
                     end else begin
                        sh_r     <= {sh_r[6:0], 1'b0};
                        o_sda_oe <= ~sh_r[6];
                     end
                  end
               end
               st_tack: begin
                  // advance on ack at the rise so the next byte is ready by the fall
                  if (scl_rise) begin
                     if (!sda_in) begin
                        o_rd_next <= 1'b1;
                     end else begin
                        state_r <= st_idle;
                     end
                  end else if (scl_fall) begin
                     sh_r     <= i_tx_byte;
                     o_sda_oe <= ~i_tx_byte[7];
                     cnt_r    <= 4'h0;
                     state_r  <= st_tx;
                  end
               end
               default: begin
                  state_r  <= st_idle;
                  o_sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : pmr_i2c_slave

// ===== verif/pmr_host_model.sv
// host side model: drives the serial clock and data line and moves register values
`timescale 1ns/100ps
module pmr_host_model (
   output logic      o_scl,
   output logic      o_sda_oe,
   input  wire logic i_sda
);
   // quarter bit time; each clock phase lasts 8 system clocks
   localparam time Q = 400;
   int nack_cnt = 0;
   // idle bus: clock high, data released to its pull-up
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // data moves mid low phase so no edge is mistaken for a start or stop
   task automatic xbit(input logic b, output logic r);
      #Q o_sda_oe = ~b;
      #Q o_scl = 1'b1;
      #(2*Q) r = i_sda;
      o_scl = 1'b0;
   endtask : xbit
   // start, also usable as a repeated start after a byte
   task automatic start();
      #Q o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b0;
   endtask : start
   task automatic stop();
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b0;
   endtask : stop
   // one byte plus the acknowledge slot; chk counts a missing device ack
   task automatic xfer(input logic [7:0] d, input logic m_ack, input logic chk,
                       output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(m_ack, a);
      if (chk && a) nack_cnt++;
   endtask : xfer
   // write pairs high byte then low byte
   task automatic wr16(input logic [7:0] p, input logic [15:0] v);
      logic [7:0] r;
      start();
      xfer({pmr_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      xfer(p, 1'b1, 1'b1, r);
      xfer(v[15:8], 1'b1, 1'b1, r);
      xfer(v[7:0], 1'b1, 1'b1, r);
      stop();
   endtask : wr16
   // read n bytes most significant first, last byte not acknowledged
   task automatic rd(input logic [7:0] p, input int n, output logic [39:0] v);
      logic [7:0] r;
      v = '0;
      start();
      xfer({pmr_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      xfer(p, 1'b1, 1'b1, r);
      start();
      xfer({pmr_pkg::DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, (i == n - 1), 1'b0, r);
         v = {v[31:0], r};
      end
      stop();
   endtask : rd
endmodule : pmr_host_model

// ===== verif/pmr_result_regs_tb_top.sv
// testbench: reset values, field encodings and alert modes of the result bank
`timescale 1ns/100ps
module pmr_result_regs_tb_top;
   logic        i_clk, i_nrst, rv, cd, fs, fa, scl, h_oe, d_oe, aoe, aflag, acs, sdo, ao;
   logic [19:0] sv, bv, cu;
   logic [15:0] dt;
   logic [23:0] pw;
   logic [39:0] en, ch, v;
   logic [14:0] scale;
   logic [13:0] drift;
   logic [16:0] delta;
   int          n_errors = 0;
   int          samples_checked = 0;
   // open drain data line with pull-up
   wire         sda = ~(h_oe | d_oe);
   pmr_host_model HOST (.o_scl(scl), .o_sda_oe(h_oe), .i_sda(sda));
   pmr_result_regs DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
      .o_sda_o(sdo), .o_sda_oe(d_oe), .o_alert_o(ao), .o_alert_oe(aoe),
      .i_result_valid(rv), .i_shunt_v(sv), .i_bus_v(bv), .i_die_temp(dt),
      .i_current(cu), .i_power(pw), .i_energy(en), .i_charge(ch), .i_conv_done(cd),
      .i_fault_sample(fs), .i_fault_avg(fa), .o_shunt_scale_constant(scale),
      .o_shunt_drift_coefficient(drift), .o_drift_temp_delta(delta),
      .o_averaged_compare_select(acs), .o_alert_flag(aflag));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic report_and_stop();
      if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // inputs always move 10 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #10;
   endtask : tick
   function automatic int nb(input logic [7:0] p);
      if (p == 8'h06) return 2;
      return (p >= 8'h09) ? 5 : 3;
   endfunction : nb
   // expected read images: reserved low nibbles read zero
   function automatic logic [39:0] ev(input logic [7:0] p);
      case (p)
         8'h04: return {16'h0, sv, 4'h0};
         8'h05: return {16'h0, bv, 4'h0};
         8'h06: return {24'h0, dt};
         8'h07: return {16'h0, cu, 4'h0};
         8'h08: return {16'h0, pw};
         8'h09: return en;
         default: return ch;
      endcase
   endfunction : ev
   // a hang is cut short here
   initial begin
      repeat (100000) @(posedge i_clk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      {i_nrst, rv, cd, fs, fa} = 5'h00;
      {sv, bv, dt, cu} = {20'h80001, 20'h7FFFF, 16'h0C81, 20'hA5A5A};
      {pw, en, ch} = {24'hFEDCBA, 40'h123456789A, 40'h80000000FF};
      tick(5);
      i_nrst = 1'b1;
      tick(3);
      chk(40'(delta), 40'h1F380);
      chk(40'(scale), 40'h1000);
      HOST.rd(8'h02, 2, v); chk(v, 40'h1000);
      HOST.rd(8'h03, 2, v); chk(v, 40'h0);
      HOST.rd(8'h0B, 2, v); chk(v, 40'h0001);
      for (int p = 4; p <= 10; p++) begin
         HOST.rd(8'(p), nb(8'(p)), v); chk(v, 40'h0);
      end
      HOST.wr16(8'h02, 16'hFFFF);
      HOST.rd(8'h02, 2, v); chk(v, 40'h7FFF);
      chk(40'(scale), 40'h7FFF);
      HOST.wr16(8'h03, 16'hFFFF);
      HOST.rd(8'h03, 2, v); chk(v, 40'h3FFF);
      chk(40'(drift), 40'h3FFF);
      rv = 1'b1;
      tick(1);
      rv = 1'b0;
      tick(3);
      chk(40'(delta), 40'h1);
      // every result register, sign bits set in the shunt, current and charge fields
      for (int p = 4; p <= 10; p++) begin
         HOST.rd(8'(p), nb(8'(p)), v); chk(v, ev(8'(p)));
      end
      HOST.wr16(8'h08, 16'h1111);
      HOST.rd(8'h08, 3, v); chk(v, 40'hFEDCBA);
      // a result update in mid-read must not tear the bytes already taken
      en = 40'h0;
      fork
         HOST.rd(8'h09, 5, v);
         begin
            tick(700);
            rv = 1'b1;
            tick(1);
            rv = 1'b0;
         end
      join
      chk(v, 40'h123456789A);
      HOST.rd(8'h09, 5, v); chk(v, 40'h0);
      HOST.rd(8'h0C, 2, v); chk(v, 40'h0);
      // transparent mode, raw then averaged sample compare
      fa = 1'b1;
      tick(3); chk(40'(aoe), 40'h0);
      fa = 1'b0;
      fs = 1'b1;
      tick(3); chk(40'({aflag, aoe}), 40'h3);
      fs = 1'b0;
      tick(3); chk(40'({aflag, aoe}), 40'h0);
      HOST.wr16(8'h0B, 16'h2000);
      chk(40'(acs), 40'h1);
      fa = 1'b1;
      tick(3); chk(40'(aoe), 40'h1);
      fa = 1'b0;
      tick(3); chk(40'(aoe), 40'h0);
      // latched mode holds until the diagnostic read
      HOST.wr16(8'h0B, 16'h8000);
      fs = 1'b1;
      tick(1);
      fs = 1'b0;
      tick(5); chk(40'({aflag, aoe}), 40'h3);
      chk(40'({sdo, ao}), 40'h0);
      HOST.rd(8'h0B, 2, v); chk(v, 40'h8081);
      tick(3); chk(40'({aflag, aoe}), 40'h0);
      // conversion ready routed to the alert pin
      HOST.wr16(8'h0B, 16'h4000);
      cd = 1'b1;
      tick(1);
      cd = 1'b0;
      tick(3); chk(40'(aoe), 40'h1);
      HOST.rd(8'h0B, 2, v); chk(v, 40'h4003);
      chk(40'(HOST.nack_cnt), 40'h0);
      report_and_stop();
   end
endmodule : pmr_result_regs_tb_top
